// >>> include/pfsc_pkg.sv
// Shared constants, types and width arithmetic for the parallel FFT scaling datapath
package pfsc_pkg;

    // ********************************************************
    // Constants
    // ********************************************************
    localparam int PFSC_CAP_W     = 27;
    localparam int PFSC_TW_W_DEF  = 18;
    localparam int PFSC_TW_IL_DEF = 2;
    localparam int PFSC_N_DEF     = 64;
    localparam int PFSC_IN_IL_DEF = 8;
    localparam int PFSC_IN_FL_DEF = 8;

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum {
        PFSC_NO_SCALE,
        PFSC_CAPPED_GROWTH_MODE,
        PFSC_SHIFT_SCALE
    } pfsc_scale_e;

    typedef enum {
        PFSC_LANES_2,
        PFSC_LANES_4,
        PFSC_LANES_8,
        PFSC_LANES_16
    } pfsc_lanes_e;

    typedef struct packed {
        logic valid;
        logic first;
    } pfsc_tag_s;

    // ********************************************************
    // Width arithmetic
    // ********************************************************
    function automatic int pfsc_lanes_log2(input pfsc_lanes_e lanes);
        return int'(lanes) + 1;
    endfunction : pfsc_lanes_log2

    // Word width after a number of stages under a scaling mode
    function automatic int pfsc_stage_w(input int in_w, input int log2r, input pfsc_scale_e mode, input int stages);
        int w;
        int grown;
        w = in_w;
        for (int s = 0; s < stages; s++) begin
            grown = w + log2r;
            unique case (mode)
                PFSC_NO_SCALE:           w = grown;                                         // RQ3
                PFSC_CAPPED_GROWTH_MODE: w = (grown <= PFSC_CAP_W) ? grown :
                                             ((w > PFSC_CAP_W) ? w : PFSC_CAP_W);            // RQ4 RQ10
                PFSC_SHIFT_SCALE:        w = w;                                             // RQ5
            endcase
        end
        return w;
    endfunction : pfsc_stage_w

endpackage : pfsc_pkg

// >>> rtl/pfsc_fft_core.sv
// Parallel-sample stage chain with per-stage bit-growth and scaling control
// Operation
// (RQ1) Only complex fixed-point samples enter the hardware; floating types are simulation only.
// (RQ2) Each sample has signed real and imaginary parts, width equals integer plus fraction bits.
// (RQ3) Unbounded mode: no scaling, each stage grows log2(R) bits over logR(N) stages.
// (RQ4) Capped mode: grow while fitting the multiplier input, then scale instead.
// (RQ5) Shift mode: every stage right-shifts by log2(R); width stays constant.
// (RQ6) Twiddle table defaults to 18-bit words with 2 signed integer bits.
// (RQ7) Twiddle word width is configurable; wider words still compute correctly.
// (RQ8) Linear chain of stages; scaling applied at every stage boundary.
// (RQ9) Parallel factor limited to 2, 4, 8 or 16.
// (RQ10) Capped mode stops growing at 27 bits and saturates there.
// (RQ11) A new transform is accepted every L/R clock cycles.
// (RQ12) Mode, length, parallel factor and twiddle widths are elaboration-time parameters.
`timescale 1ns/100ps

module pfsc_fft_core #(
    parameter pfsc_pkg::pfsc_lanes_e LANES    = pfsc_pkg::PFSC_LANES_4,                    // RQ9
    parameter int                    N        = pfsc_pkg::PFSC_N_DEF,
    parameter int                    IN_IL    = pfsc_pkg::PFSC_IN_IL_DEF,
    parameter int                    IN_FL    = pfsc_pkg::PFSC_IN_FL_DEF,
    parameter pfsc_pkg::pfsc_scale_e MODE     = pfsc_pkg::PFSC_NO_SCALE,
    parameter int                    TW_W     = pfsc_pkg::PFSC_TW_W_DEF,
    parameter int                    TW_IL    = pfsc_pkg::PFSC_TW_IL_DEF,
    localparam int                   LOG2R    = pfsc_pkg::pfsc_lanes_log2(LANES),
    localparam int                   R        = 1 << LOG2R,
    localparam int                   LOG2N    = $clog2(N),
    localparam int                   NSTG     = LOG2N / LOG2R,
    localparam int                   IN_W     = IN_IL + IN_FL,
    localparam int                   OUT_W    = pfsc_pkg::pfsc_stage_w(IN_W, LOG2R, MODE, NSTG)
) (
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    // Input wide stream
    input  wire logic                  in_valid,
    output logic                       in_ready,
    input  wire logic [R*IN_W-1:0]     in_re,
    input  wire logic [R*IN_W-1:0]     in_im,
    // Output wide stream
    output logic                       out_valid,
    input  wire logic                  out_ready,
    output logic                       out_first,
    output logic [R*OUT_W-1:0]         out_re,
    output logic [R*OUT_W-1:0]         out_im
);
    import pfsc_pkg::*;

    // ********************************************************
    // Derived sizes and twiddle tables
    // ********************************************************
    localparam int MAXW  = IN_W + NSTG * LOG2R + 1;
    localparam int TW_FB = TW_W - TW_IL;
    localparam int TPF   = N / R;
    localparam int TW_T  = (TPF > 1) ? $clog2(TPF) : 1;

    typedef logic signed [TW_W-1:0] pfsc_tab_t [N];
    typedef logic signed [MAXW-1:0] pfsc_lane_t [R];

    // Fixed-point rounding of exp(-j*2*pi*k/N) into TW_W bits
    function automatic pfsc_tab_t pfsc_make_tab(input bit sine);
        pfsc_tab_t tab;
        real       v;
        for (int k = 0; k < N; k++) begin
            v = sine ? -$sin(2.0 * 3.14159265358979 * k / N) : $cos(2.0 * 3.14159265358979 * k / N);
            tab[k] = TW_W'($rtoi(v * (2.0 ** TW_FB) + ((v >= 0.0) ? 0.5 : -0.5)));  // RQ6 RQ7
        end
        return tab;
    endfunction : pfsc_make_tab

    localparam pfsc_tab_t COS_TAB = pfsc_make_tab(1'b0);
    localparam pfsc_tab_t SIN_TAB = pfsc_make_tab(1'b1);

    // Product pair sum scaled back by the twiddle fraction bits
    function automatic logic signed [MAXW-1:0] pfsc_dot(input logic signed [MAXW:0] a, input logic signed [TW_W-1:0] c,
                                                        input logic signed [MAXW:0] b, input logic signed [TW_W-1:0] d);
        logic signed [MAXW+TW_W+1:0] acc;
        acc = (MAXW+TW_W+2)'(a * c) + (MAXW+TW_W+2)'(b * d);
        return MAXW'(acc >>> TW_FB);
    endfunction : pfsc_dot

    // Keep the low w bits of a value, sign-extended to MAXW
    function automatic logic signed [MAXW-1:0] pfsc_sext(input logic signed [MAXW-1:0] v, input int w);
        return (v <<< (MAXW - w)) >>> (MAXW - w);
    endfunction : pfsc_sext

    // Twiddle index for lane r at frame time t in stage s, modulo N
    function automatic logic [LOG2N-1:0] pfsc_tw_idx(input int r, input logic [TW_T-1:0] t, input int s);
        return LOG2N'(r * int'(t) * (1 << (s * LOG2R)));
    endfunction : pfsc_tw_idx

    // ********************************************************
    // Stream control
    // ********************************************************
    pfsc_lane_t        st_re [0:NSTG];
    pfsc_lane_t        st_im [0:NSTG];
    pfsc_tag_s         st_tag [0:NSTG];
    logic [TW_T-1:0]   st_t [0:NSTG];
    logic              adv;
    logic [TW_T-1:0]   frame_t;
    logic [TW_T-1:0]   next_frame_t;
    pfsc_lane_t        in_q_re;
    pfsc_lane_t        in_q_im;
    pfsc_lane_t        next_in_re;
    pfsc_lane_t        next_in_im;
    pfsc_tag_s         in_q_tag;
    pfsc_tag_s         next_in_tag;
    logic [TW_T-1:0]   in_q_t;
    logic [TW_T-1:0]   next_in_t;

    assign adv      = !st_tag[NSTG].valid || out_ready;
    assign in_ready = adv;

    // ********************************************************
    // Input register and frame counter
    // ********************************************************
    always_comb begin
        next_frame_t = frame_t;
        next_in_re   = in_q_re;
        next_in_im   = in_q_im;
        next_in_tag  = in_q_tag;
        next_in_t    = in_q_t;
        if (adv) begin
            next_in_tag.valid = in_valid;
            next_in_tag.first = in_valid && (frame_t == '0);
            next_in_t         = frame_t;
            for (int r = 0; r < R; r++) begin
                next_in_re[r] = MAXW'($signed(in_re[r*IN_W +: IN_W]));                        // RQ1 RQ2
                next_in_im[r] = MAXW'($signed(in_im[r*IN_W +: IN_W]));                        // RQ2
            end
            if (in_valid) begin
                next_frame_t = (int'(frame_t) == TPF - 1) ? '0 : TW_T'(int'(frame_t) + 1);   // RQ11
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            frame_t  <= '0;
            in_q_tag <= '0;
            in_q_t   <= '0;
            in_q_re  <= '{default: '0};
            in_q_im  <= '{default: '0};
        end else begin
            frame_t  <= next_frame_t;
            in_q_tag <= next_in_tag;
            in_q_t   <= next_in_t;
            in_q_re  <= next_in_re;
            in_q_im  <= next_in_im;
        end
    end

    assign st_re[0]  = in_q_re;
    assign st_im[0]  = in_q_im;
    assign st_tag[0] = in_q_tag;
    assign st_t[0]   = in_q_t;

    // ********************************************************
    // Stage chain
    // ********************************************************
    for (genvar s = 0; s < NSTG; s++) begin : g_stg                                          // RQ8 RQ12
        localparam int WI = pfsc_stage_w(IN_W, LOG2R, MODE, s);
        localparam int WO = pfsc_stage_w(IN_W, LOG2R, MODE, s + 1);
        localparam int SH = WI + LOG2R - WO;

        pfsc_lane_t      q_re;
        pfsc_lane_t      q_im;
        pfsc_tag_s       q_tag;
        logic [TW_T-1:0] q_t;
        pfsc_lane_t      next_re;
        pfsc_lane_t      next_im;
        pfsc_tag_s       next_tag;
        logic [TW_T-1:0] next_t;

        always_comb begin
            pfsc_lane_t        br;
            pfsc_lane_t        bi;
            logic signed [MAXW-1:0] ar;
            logic signed [MAXW-1:0] ai;
            logic [LOG2N-1:0]  k;
            br = '{default: '0};
            bi = '{default: '0};
            ar = '0;
            ai = '0;
            k  = '0;
            // Twiddle rotation per lane
            for (int r = 0; r < R; r++) begin
                k     = pfsc_tw_idx(r, st_t[s], s);
                br[r] = pfsc_dot((MAXW+1)'(st_re[s][r]), COS_TAB[k], -((MAXW+1)'(st_im[s][r])), SIN_TAB[k]); // RQ7
                bi[r] = pfsc_dot((MAXW+1)'(st_im[s][r]), COS_TAB[k], (MAXW+1)'(st_re[s][r]), SIN_TAB[k]);
            end
            // Radix-R combine across lanes, one bit of growth per level
            for (int l = 0; l < LOG2R; l++) begin
                for (int r = 0; r < R; r++) begin
                    if ((r & (1 << l)) == 0) begin
                        ar           = br[r];
                        ai           = bi[r];
                        br[r]        = ar + br[r | (1 << l)];
                        bi[r]        = ai + bi[r | (1 << l)];
                        br[r | (1 << l)] = ar - br[r | (1 << l)];
                        bi[r | (1 << l)] = ai - bi[r | (1 << l)];
                    end
                end
            end
            // Stage boundary scaling to the mode's width
            next_re  = q_re;
            next_im  = q_im;
            next_tag = q_tag;
            next_t   = q_t;
            if (adv) begin
                next_tag = st_tag[s];
                next_t   = st_t[s];
                for (int r = 0; r < R; r++) begin
                    next_re[r] = pfsc_sext(br[r] >>> SH, WO);                                 // RQ3 RQ4 RQ5 RQ10
                    next_im[r] = pfsc_sext(bi[r] >>> SH, WO);                                 // RQ3 RQ4 RQ5 RQ10
                end
            end
        end

        always_ff @(posedge core_clk) begin
            if (rst) begin
                q_tag <= '0;
                q_t   <= '0;
                q_re  <= '{default: '0};
                q_im  <= '{default: '0};
            end else begin
                q_tag <= next_tag;
                q_t   <= next_t;
                q_re  <= next_re;
                q_im  <= next_im;
            end
        end

        assign st_re[s+1]  = q_re;                                                            // RQ8
        assign st_im[s+1]  = q_im;
        assign st_tag[s+1] = q_tag;
        assign st_t[s+1]   = q_t;
    end

    // ********************************************************
    // Output packing
    // ********************************************************
    assign out_valid = st_tag[NSTG].valid;
    assign out_first = st_tag[NSTG].first;

    for (genvar r = 0; r < R; r++) begin : g_out
        assign out_re[r*OUT_W +: OUT_W] = st_re[NSTG][r][OUT_W-1:0];
        assign out_im[r*OUT_W +: OUT_W] = st_im[NSTG][r][OUT_W-1:0];
    end

endmodule : pfsc_fft_core

// >>> test/pfsc_fft_core_props.sv
// Stream flow and frame marking checker for the FFT core
`timescale 1ns/100ps
module pfsc_fft_core_props #(
    parameter pfsc_pkg::pfsc_lanes_e LANES = pfsc_pkg::PFSC_LANES_4,
    parameter int                    N     = 64,
    parameter int                    IN_W  = 16,
    parameter int                    OUT_W = 22,
    localparam int                   R     = 2 << int'(LANES),
    localparam int                   BEATS = N / R
) (
    // Clock and reset
    input wire logic               core_clk,
    input wire logic               rst,
    // Streams
    input wire logic               in_valid,
    input wire logic               in_ready,
    input wire logic [R*IN_W-1:0]  in_re,
    input wire logic [R*IN_W-1:0]  in_im,
    input wire logic               out_valid,
    input wire logic               out_ready,
    input wire logic               out_first,
    input wire logic [R*OUT_W-1:0] out_re,
    input wire logic [R*OUT_W-1:0] out_im
);
    import pfsc_pkg::*;
    int icnt;
    int ocnt;
    int next_icnt;
    int next_ocnt;
    always_comb begin
        next_icnt = icnt;
        next_ocnt = ocnt;
        if (in_valid && in_ready) next_icnt = (icnt == BEATS - 1) ? 0 : icnt + 1;
        if (out_valid && out_ready) next_ocnt = (ocnt == BEATS - 1) ? 0 : ocnt + 1;
        if (rst) next_icnt = 0;
        if (rst) next_ocnt = 0;
    end
    always_ff @(posedge core_clk) begin
        icnt <= next_icnt;
        ocnt <= next_ocnt;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_ready_follow: assert property (in_ready == (!out_valid || out_ready))
        else $error("in_ready does not follow output stall");
    chk_stall_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_re)
        && $stable(out_im) && $stable(out_first)) else $error("stalled beat changed");
    chk_pipe_latency: assert property (in_valid && in_ready ##1 out_ready[*3] |=> out_valid)
        else $error("beat not out after chain latency");
    chk_pipe_drain: assert property ((!in_valid && out_ready)[*4] |=> !out_valid)
        else $error("beat appeared from nowhere");
    chk_first_lat: assert property (in_valid && in_ready && icnt == 0 ##1 out_ready[*3]
        |=> out_valid && out_first) else $error("frame start not marked");
    chk_first_pos: assert property (out_valid && out_first |-> ocnt == 0)
        else $error("frame start marked mid frame");
    chk_first_each: assert property (out_valid && ocnt == 0 |-> out_first)
        else $error("frame start mark missing");
    chk_reset_quiet: assert property (disable iff (1'b0) rst |=> !out_valid && !out_first)
        else $error("output valid after reset");
endmodule : pfsc_fft_core_props
bind pfsc_fft_core pfsc_fft_core_props #(.LANES(LANES), .N(N), .IN_W(IN_W), .OUT_W(OUT_W)) u_props (
    .core_clk(core_clk), .rst(rst), .in_valid(in_valid), .in_ready(in_ready), .in_re(in_re),
    .in_im(in_im), .out_valid(out_valid), .out_ready(out_ready), .out_first(out_first),
    .out_re(out_re), .out_im(out_im));

// >>> test/pfsc_sink_model.sv
// Downstream consumer model, prompt or stalling every other cycle
`timescale 1ns/100ps
module pfsc_sink_model (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // Stream
    input  wire logic slow,
    input  wire logic out_valid,
    input  wire logic out_first,
    output logic      out_ready,
    output int        frames
);
    logic next_ready;
    int   next_frames;
    always_comb begin
        next_ready = slow ? !out_ready : 1'b1;
        next_frames = (out_valid && out_ready && out_first) ? frames + 1 : frames;
        if (rst) next_ready = 1'b1;
        if (rst) next_frames = 0;
    end
    always_ff @(posedge core_clk) begin
        out_ready <= next_ready;
        frames <= next_frames;
    end
endmodule : pfsc_sink_model

// >>> test/pfsc_fft_core_test.sv
// Self-checking bench for the FFT core scaling datapath
`timescale 1ns/100ps
module pfsc_fft_core_test;
    import pfsc_pkg::*;
    localparam int R = 4;
    localparam int W = 16;
    localparam int OW = 22;
    localparam int OWR = R * OW;
    localparam int CW = 24;
    localparam int CO = 27;
    logic c_valid, c_first;
    logic [R*CW-1:0] c_in_re, c_in_im;
    logic [R*CO-1:0] c_re;
    logic core_clk, rst, in_valid, in_ready, out_valid, out_ready, out_first, slow, s_valid, s_first;
    logic [R*W-1:0] in_re, in_im, s_re;
    logic [OWR-1:0] out_re, out_im;
    logic [W-1:0] xs [6] = '{16'h0100, 16'hff00, 16'h7f00, 16'h0010, 16'h8000, 16'h0000};
    int xq[$];
    int ex, frames, num_errors, samples_checked, cycles;
    pfsc_fft_core i_dut (.core_clk(core_clk), .rst(rst), .in_valid(in_valid), .in_ready(in_ready),
        .in_re(in_re), .in_im(in_im), .out_valid(out_valid), .out_ready(out_ready),
        .out_first(out_first), .out_re(out_re), .out_im(out_im));
    pfsc_fft_core #(.MODE(PFSC_SHIFT_SCALE)) i_shift (.core_clk(core_clk), .rst(rst),
        .in_valid(in_valid), .in_ready(), .in_re(in_re), .in_im(in_im), .out_valid(s_valid),
        .out_ready(out_ready), .out_first(s_first), .out_re(s_re), .out_im());
    pfsc_fft_core #(.MODE(PFSC_CAPPED_GROWTH_MODE), .IN_IL(12), .IN_FL(12)) i_cap (.core_clk(core_clk),
        .rst(rst), .in_valid(in_valid), .in_ready(), .in_re(c_in_re), .in_im(c_in_im), .out_valid(c_valid),
        .out_ready(out_ready), .out_first(c_first), .out_re(c_re), .out_im());
    pfsc_sink_model i_sink (.core_clk(core_clk), .rst(rst), .slow(slow), .out_valid(out_valid),
        .out_first(out_first), .out_ready(out_ready), .frames(frames));
    // ********************************
    // Tasks
    // ********************************
    function automatic logic signed [31:0] lsum(input logic [127:0] v, input int w);
        logic signed [31:0] t;
        lsum = 0;
        for (int r = 0; r < R; r++) begin
            t = 32'(v >> (r * w)) << (32 - w);
            lsum = lsum + (t >>> (32 - w));
        end
    endfunction : lsum
    task automatic chk(input string what, input logic signed [31:0] e, input logic signed [31:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, e, g);
        end
    endtask : chk
    task automatic close_out;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out
    task automatic frame(input logic [W-1:0] x);
        xq.push_back(int'($signed(x)));
        for (int t = 0; t < 16; t++) begin
            in_re <= (t == 0) ? {{(R-1)*W{1'b0}}, x} : '0;
            in_im <= (t == 0) ? {{(R-1)*W{1'b0}}, ~x} : '0;
            c_in_re <= (t == 0) ? {{(R-1)*CW{1'b0}}, {(CW-W){x[W-1]}}, x} : '0;
            c_in_im <= (t == 0) ? {{(R-1)*CW{1'b0}}, {(CW-W){~x[W-1]}}, ~x} : '0;
            in_valid <= 1'b1;
            forever begin
                @(negedge core_clk);
                if (in_ready) break;
            end
            @(posedge core_clk);
        end
    endtask : frame
    // ********************************
    // Monitor, clock and sequence
    // ********************************
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            close_out();
        end
        if (!rst && out_valid && out_ready && out_first) begin
            ex = xq.pop_front();
            chk("dut_re_sum", 16 * ex, lsum(128'(out_re), OW));
            chk("dut_im_sum", -16 * ex - 16, lsum(128'(out_im), OW));
            chk("shift_re_sum", ex / 4, lsum(128'(s_re), W));
            chk("shift_first", 1, 32'(s_valid & s_first));
            chk("cap_re_sum", 2 * ex, lsum(128'(c_re), CO));
            chk("cap_first", 1, 32'(c_valid & c_first));
        end else if (!rst && out_valid && out_ready) begin
            chk("dut_re_rest", 0, lsum(128'(out_re), OW));
        end
    end
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = !core_clk;
    end
    initial begin
        {rst, in_valid, in_re, in_im, c_in_re, c_in_im, slow, cycles, num_errors, samples_checked} = '0;
        rst = 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        chk("out_width", R * (W + 3 * 2), $bits(i_dut.out_re));
        chk("shift_width", R * W, $bits(i_shift.out_re));
        chk("cap_width", R * PFSC_CAP_W, $bits(i_cap.out_re));
        repeat (5) @(posedge core_clk);
        for (int p = 0; p < 6; p++) begin
            slow <= (p >= 3);
            frame(xs[p]);
        end
        in_valid <= 1'b0;
        slow <= 1'b0;
        while (frames < 6) @(posedge core_clk);
        repeat (8) @(posedge core_clk);
        chk("frames", 6, frames);
        close_out();
    end
endmodule : pfsc_fft_core_test
